// *** design/encoder_pulse_divider.sv ***
// encoder pulse divider with apb registers and quadrature-preserving output
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module encoder_pulse_divider (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [enc_div_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // option hardware
    input wire logic option_present,
    // encoder phases in
    input wire logic phase_a_pulse_in,
    input wire logic phase_b_pulse_in,
    // divided phases out
    output logic divided_phase_a_out,
    output logic divided_phase_b_out
);

    // =====================================================================
    // registers and bus decode
    // =====================================================================
    logic [15:0] ratio_q;
    logic [enc_div_pkg::FILT_W-1:0] filter_q;
    logic reject_q;
    logic access;
    logic prepare;
    logic commit;
    logic wr_ratio;
    logic wr_filter;
    logic wr_status;
    logic wr_step;
    logic ratio_ok;
    logic filter_ok;
    logic mapped;
    logic [31:0] rd_value;

    assign access = psel & penable;
    assign prepare = access & ~pready;
    assign commit = access & pready & pwrite;
    assign wr_ratio = commit && paddr == enc_div_pkg::RATIO_ADDR;
    assign wr_filter = commit && paddr == enc_div_pkg::FILTER_ADDR;
    assign wr_status = commit && paddr == enc_div_pkg::STATUS_ADDR;
    assign wr_step = commit && paddr == enc_div_pkg::STEP_ADDR;
    assign ratio_ok = pwdata[31:16] == 16'h0000 && enc_div_pkg::ratio_legal(pwdata[15:0]);
    assign filter_ok = pwdata[31:16] == 16'h0000 && pwdata[15:0] <= enc_div_pkg::FILTER_MAX;

    always_comb begin
        rd_value = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            enc_div_pkg::RATIO_ADDR: begin
                rd_value[15:0] = ratio_q;
            end
            enc_div_pkg::FILTER_ADDR: begin
                rd_value[enc_div_pkg::FILT_W-1:0] = filter_q;
            end
            enc_div_pkg::STATUS_ADDR: begin
                rd_value[enc_div_pkg::STAT_PRESENT_BIT] = option_present;
                rd_value[enc_div_pkg::STAT_REJECT_BIT] = reject_q;
            end
            enc_div_pkg::STEP_ADDR: begin
                rd_value = 32'h0000_0000;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // one wait state: ready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= prepare;
            prdata <= (prepare && !pwrite) ? rd_value : 32'h0000_0000;
            pslverr <= prepare && (!mapped || (pwrite && paddr == enc_div_pkg::RATIO_ADDR && !ratio_ok)
                                   || (pwrite && paddr == enc_div_pkg::FILTER_ADDR && !filter_ok));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_q <= enc_div_pkg::RATIO_RESET;
        end else if (wr_ratio && ratio_ok) begin
            ratio_q <= pwdata[15:0];
        end else if (wr_step && pwdata[enc_div_pkg::STEP_UP_BIT]) begin
            ratio_q <= enc_div_pkg::ratio_up(ratio_q);
        end else if (wr_step && pwdata[enc_div_pkg::STEP_DOWN_BIT]) begin
            ratio_q <= enc_div_pkg::ratio_down(ratio_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_q <= enc_div_pkg::FILTER_RESET;
        end else if (wr_filter && filter_ok) begin
            filter_q <= pwdata[enc_div_pkg::FILT_W-1:0];
        end
    end

    // rejected write flag, set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_q <= 1'b0;
        end else if ((wr_ratio && !ratio_ok) || (wr_filter && !filter_ok)) begin
            reject_q <= 1'b1;
        end else if (wr_status && pwdata[enc_div_pkg::STAT_REJECT_BIT]) begin
            reject_q <= 1'b0;
        end
    end

    // =====================================================================
    // input filtering
    // =====================================================================
    logic [1:0] phase_raw;
    logic [1:0] phase_filt;

    assign phase_raw = {phase_b_pulse_in, phase_a_pulse_in};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_filt
            edge_filter #(
                .CNT_W(enc_div_pkg::FILT_W)
            ) u_filt (
                .pclk(pclk),
                .presetn(presetn),
                .sample_in(phase_raw[i]),
                .setting(filter_q),
                .stable_out(phase_filt[i])
            );
        end
    endgenerate

    // =====================================================================
    // quadrature step counting and division
    // =====================================================================
    logic [1:0] prev_pos_q;
    logic [1:0] in_pos;
    logic [1:0] in_diff;
    logic [1:0] out_pos;
    logic [1:0] out_next;
    logic step_fwd;
    logic step_rev;
    logic out_fwd;
    logic out_rev;
    logic signed [9:0] acc_q;
    logic signed [9:0] acc_d;
    logic signed [9:0] sum;
    logic signed [9:0] num_s;
    logic signed [9:0] den_s;

    // gray phase to position: forward is 00,01,11,10 on {a,b}
    assign in_pos = {phase_filt[0], phase_filt[0] ^ phase_filt[1]};
    assign in_diff = in_pos - prev_pos_q;
    assign step_fwd = in_diff == 2'h1;
    assign step_rev = in_diff == 2'h3;
    assign out_pos = {divided_phase_a_out, divided_phase_a_out ^ divided_phase_b_out};
    assign num_s = $signed({8'h00, enc_div_pkg::ratio_num(ratio_q)});
    assign den_s = $signed({2'b00, enc_div_pkg::ratio_den(ratio_q)});

    always_comb begin
        acc_d = acc_q;
        sum = acc_q;
        out_fwd = 1'b0;
        out_rev = 1'b0;
        if (step_fwd) begin
            sum = acc_q + num_s;
            if (sum >= den_s) begin
                acc_d = sum - den_s;
                out_fwd = 1'b1;
            end else begin
                acc_d = sum;
            end
        end else if (step_rev) begin
            sum = acc_q - num_s;
            if (sum <= -den_s) begin
                acc_d = sum + den_s;
                out_rev = 1'b1;
            end else begin
                acc_d = sum;
            end
        end
    end

    // output moves one step in the direction of the input step
    assign out_next = out_fwd ? out_pos + 2'h1 : (out_rev ? out_pos - 2'h1 : out_pos);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_pos_q <= 2'h0;
        end else begin
            prev_pos_q <= in_pos;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
        end else if (!option_present || wr_ratio || wr_step) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divided_phase_a_out <= 1'b0;
            divided_phase_b_out <= 1'b0;
        end else if (!option_present) begin
            divided_phase_a_out <= 1'b0;
            divided_phase_b_out <= 1'b0;
        end else begin
            divided_phase_a_out <= out_next[1];
            divided_phase_b_out <= out_next[1] ^ out_next[0];
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    sequence s_up_at_top;
        wr_step && pwdata[enc_div_pkg::STEP_UP_BIT] && ratio_q == enc_div_pkg::M_MAX;
    endsequence

    sequence s_down_at_base;
        wr_step && !pwdata[enc_div_pkg::STEP_UP_BIT] && pwdata[enc_div_pkg::STEP_DOWN_BIT]
            && ratio_q == enc_div_pkg::N1_MIN;
    endsequence

    property p_ratio_legal;
        @(posedge pclk) disable iff (!presetn) enc_div_pkg::ratio_legal(ratio_q);
    endproperty
    a_ratio_legal: assert property (p_ratio_legal) else $error("ratio setting out of range");

    property p_reject;
        @(posedge pclk) disable iff (!presetn) (wr_ratio && !ratio_ok) |=> $stable(ratio_q) && reject_q;
    endproperty
    a_reject: assert property (p_reject) else $error("illegal ratio accepted");

    property p_up_jump;
        @(posedge pclk) disable iff (!presetn) s_up_at_top |=> ratio_q == enc_div_pkg::N1_MIN;
    endproperty
    a_up_jump: assert property (p_up_jump) else $error("step up did not jump past 1001");

    property p_down_jump;
        @(posedge pclk) disable iff (!presetn) s_down_at_base |=> ratio_q == enc_div_pkg::M_MAX;
    endproperty
    a_down_jump: assert property (p_down_jump) else $error("step down did not jump to 128");

    property p_filter_range;
        @(posedge pclk) disable iff (!presetn) (wr_filter && !filter_ok) |=> $stable(filter_q);
    endproperty
    a_filter_range: assert property (p_filter_range) else $error("illegal filter accepted");

    property p_absent_quiet;
        @(posedge pclk) disable iff (!presetn)
        !option_present |=> !divided_phase_a_out && !divided_phase_b_out;
    endproperty
    a_absent_quiet: assert property (p_absent_quiet) else $error("output while option absent");

    property p_unit_ratio;
        @(posedge pclk) disable iff (!presetn)
        (option_present && ratio_q == enc_div_pkg::RATIO_RESET && step_fwd) |=>
            {divided_phase_a_out, divided_phase_a_out ^ divided_phase_b_out} == $past(out_pos) + 2'h1;
    endproperty
    a_unit_ratio: assert property (p_unit_ratio) else $error("unit ratio missed a step");

    property p_direction;
        @(posedge pclk) disable iff (!presetn)
        (option_present && !step_fwd) |=>
            {divided_phase_a_out, divided_phase_a_out ^ divided_phase_b_out} != $past(out_pos) + 2'h1;
    endproperty
    a_direction: assert property (p_direction) else $error("forward output without forward input");

    property p_num_decode;
        @(posedge pclk) disable iff (!presetn)
        (ratio_q >= enc_div_pkg::THOUSAND) == (num_s == 10'sd2) && den_s >= num_s;
    endproperty
    a_num_decode: assert property (p_num_decode) else $error("ratio decode wrong");

endmodule // encoder_pulse_divider

// *** include/enc_div_pkg.sv ***
// constants, register map and ratio decoding for the encoder pulse divider
package enc_div_pkg;

    // =====================================================================
    // register map (printed offsets are word indices)
    // =====================================================================
    localparam int unsigned ADDR_W = 17;
    localparam logic [14:0] RATIO_IDX = 15'h7320;
    localparam logic [14:0] FILTER_IDX = 15'h7321;
    localparam logic [14:0] STATUS_IDX = 15'h7322;
    localparam logic [14:0] STEP_IDX = 15'h7323;
    localparam logic [ADDR_W-1:0] RATIO_ADDR = {RATIO_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] FILTER_ADDR = {FILTER_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] STEP_ADDR = {STEP_IDX, 2'b00};

    // =====================================================================
    // field layout and reset values
    // =====================================================================
    localparam int unsigned FILT_W = 4;
    localparam logic [15:0] RATIO_RESET = 16'h0001;
    localparam logic [FILT_W-1:0] FILTER_RESET = 4'h0;
    localparam logic [15:0] FILTER_MAX = 16'h000F;
    localparam int unsigned STEP_UP_BIT = 0;
    localparam int unsigned STEP_DOWN_BIT = 1;
    localparam int unsigned STAT_PRESENT_BIT = 0;
    localparam int unsigned STAT_REJECT_BIT = 1;

    // =====================================================================
    // ratio coding: value = n * 1000 + m
    // =====================================================================
    localparam logic [15:0] THOUSAND = 16'h03E8;
    localparam logic [15:0] M_MIN = 16'h0001;
    localparam logic [15:0] M_MAX = 16'h0080;
    localparam logic [15:0] N1_MIN = 16'h03EA;
    localparam logic [15:0] RATIO_MAX = 16'h0468;

    function automatic logic ratio_legal(input logic [15:0] v);
        return (v >= M_MIN && v <= M_MAX) || (v >= N1_MIN && v <= RATIO_MAX);
    endfunction

    function automatic logic [1:0] ratio_num(input logic [15:0] v);
        return (v >= THOUSAND) ? 2'h2 : 2'h1;
    endfunction

    function automatic logic [7:0] ratio_den(input logic [15:0] v);
        logic [15:0] m;
        m = (v >= THOUSAND) ? v - THOUSAND : v;
        return m[7:0];
    endfunction

    function automatic logic [15:0] ratio_up(input logic [15:0] v);
        if (v == M_MAX) begin
            return N1_MIN;
        end
        return (v >= RATIO_MAX) ? RATIO_MAX : v + M_MIN;
    endfunction

    function automatic logic [15:0] ratio_down(input logic [15:0] v);
        if (v == N1_MIN) begin
            return M_MAX;
        end
        return (v <= M_MIN) ? M_MIN : v - M_MIN;
    endfunction

endpackage

// *** design/edge_filter.sv ***
// stability filter for one encoder phase
`timescale 1ns/1ps
module edge_filter #(
    parameter int unsigned CNT_W = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sample and setting
    input wire logic sample_in,
    input wire logic [CNT_W-1:0] setting,
    // filtered level
    output logic stable_out
);

    logic [CNT_W-1:0] cnt_q;

    // a new level passes once it has differed for setting+1 samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_out <= 1'b0;
            cnt_q <= '0;
        end else if (sample_in == stable_out) begin
            cnt_q <= '0;
        end else if (cnt_q >= setting) begin
            stable_out <= sample_in;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        (setting == '0 && sample_in != stable_out) |=> stable_out == $past(sample_in);
    endproperty
    a_bypass: assert property (p_bypass) else $error("zero setting did not pass edge");

    property p_hold_short;
        @(posedge pclk) disable iff (!presetn)
        (sample_in != stable_out && cnt_q < setting) |=> stable_out == $past(stable_out);
    endproperty
    a_hold_short: assert property (p_hold_short) else $error("edge passed too early");

endmodule // edge_filter

// *** verification/counter_model.sv ***
// quadrature counter model standing at the divided outputs
`timescale 1ns/1ps
module counter_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // divided phases seen by the counter
    input wire logic phase_a,
    input wire logic phase_b,
    // decoded position and illegal jump flag
    output logic signed [15:0] pos,
    output logic jump_seen
);
    // =====================================================================
    // four steps per phase a cycle, forward is 00,01,11,10
    // =====================================================================
    logic [1:0] prev_q;
    logic [1:0] cur;

    assign cur = {phase_a, phase_b};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 2'h0;
            pos <= 16'sh0;
            jump_seen <= 1'b0;
        end else begin
            prev_q <= cur;
            if (cur === {prev_q[0], ~prev_q[1]}) begin
                pos <= pos + 16'sh1;
            end else if (cur === {~prev_q[0], prev_q[1]}) begin
                pos <= pos - 16'sh1;
            end else if (cur !== prev_q) begin
                jump_seen <= 1'b1;
            end
        end
    end
endmodule // counter_model

// *** verification/encoder_pulse_divider_tb.sv ***
// self-checking bench for the encoder pulse divider
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module encoder_pulse_divider_tb;
    // =====================================================================
    // signals and model state
    // =====================================================================
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, option_present;
    logic [16:0] paddr;
    logic [31:0] pwdata, prdata, lfsr;
    logic phase_a_pulse_in, phase_b_pulse_in, divided_phase_a_out, divided_phase_b_out, jump_seen;
    logic signed [15:0] pos, pos_prev, exp_pos;
    logic [32:0] bus_q[$];
    logic signed [15:0] pos_q[$];
    // expected values are popped once, before the compare macro evaluates them
    logic [32:0] bus_exp;
    logic signed [15:0] pos_exp;
    logic [1:0] enc;
    int miscompares, n_checks, acc, num, den, filt;
    logic [31:0] bad_tab[6] = '{32'h0, 32'h81, 32'h3E8, 32'h3E9, 32'h469, 32'h10001};
    logic [33:0] step_tab[8] = '{{16'h007F, 2'h1, 16'h0080}, {16'h0080, 2'h1, 16'h03EA},
        {16'h03EA, 2'h2, 16'h0080}, {16'h0080, 2'h2, 16'h007F}, {16'h0001, 2'h2, 16'h0001},
        {16'h0468, 2'h1, 16'h0468}, {16'h007F, 2'h3, 16'h0080}, {16'h03EA, 2'h1, 16'h03EB}};
    logic [15:0] fixed_tab[4] = '{16'h0001, 16'h0080, 16'h03EA, 16'h0468};

    encoder_pulse_divider encoder_pulse_divider_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .option_present(option_present),
        .phase_a_pulse_in(phase_a_pulse_in), .phase_b_pulse_in(phase_b_pulse_in),
        .divided_phase_a_out(divided_phase_a_out), .divided_phase_b_out(divided_phase_b_out));
    counter_model counter_model_inst (.pclk(pclk), .presetn(presetn), .phase_a(divided_phase_a_out),
        .phase_b(divided_phase_b_out), .pos(pos), .jump_seen(jump_seen));

    always #25 pclk = ~pclk;

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic complete_run();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // =====================================================================
    // apb master, expected answer noted before the request
    // =====================================================================
    task automatic apb(input logic wr, input logic [16:0] addr, input logic [31:0] data,
                       input logic [31:0] exp, input logic err);
        int i;
        bus_q.push_back({err, exp});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            miscompares++;
            complete_run();
        end
    endtask

    task automatic write_reg(input logic [16:0] addr, input logic [31:0] data, input logic err);
        apb(1'b1, addr, data, 32'h0, err);
    endtask

    task automatic read_reg(input logic [16:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0, exp, 1'b0);
    endtask

    task automatic set_ratio(input logic [15:0] v);
        write_reg(enc_div_pkg::RATIO_ADDR, {16'h0, v}, 1'b0);
        num = (v >= 16'h03E8) ? 2 : 1;
        den = (v >= 16'h03E8) ? int'(v - 16'h03E8) : int'(v);
        acc = 0;
    endtask

    // =====================================================================
    // encoder driver, output steps predicted as (1+n)/m of input steps
    // =====================================================================
    task automatic steps(input int n, input logic rnd);
        logic dir;
        repeat (n) begin
            lfsr = next_rand(lfsr);
            dir = rnd ? lfsr[0] : 1'b1;
            enc = dir ? {enc[0], ~enc[1]} : {~enc[0], enc[1]};
            @(posedge pclk);
            phase_a_pulse_in <= enc[1];
            phase_b_pulse_in <= enc[0];
            if (option_present) begin
                acc = dir ? acc + num : acc - num;
                if (acc >= den) begin
                    acc = acc - den;
                    exp_pos++;
                    pos_q.push_back(exp_pos);
                end else if (acc <= -den) begin
                    acc = acc + den;
                    exp_pos--;
                    pos_q.push_back(exp_pos);
                end
            end
            repeat (filt + 4) @(posedge pclk);
        end
    endtask

    // =====================================================================
    // result watchers
    // =====================================================================
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            bus_exp = (bus_q.size() > 0) ? bus_q.pop_front() : 33'h1FFFFFFFF;
            `CHK({pslverr, prdata}, bus_exp)
        end
        if (pos !== pos_prev) begin
            pos_exp = (pos_q.size() > 0) ? pos_q.pop_front() : 16'sh7FFF;
            `CHK(pos, pos_exp)
        end
        pos_prev <= pos;
    end

    initial begin
        repeat (90000) @(posedge pclk);
        miscompares++;
        complete_run();
    end

    initial begin
        logic [15:0] v;
        int f;
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, option_present, phase_a_pulse_in, phase_b_pulse_in} = 6'h0;
        paddr = 17'h0;
        pwdata = 32'h0;
        lfsr = 32'h9ED39D9C;
        {enc, acc, num, den, filt, exp_pos, pos_prev, miscompares, n_checks} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        read_reg(enc_div_pkg::RATIO_ADDR, 32'h1);
        read_reg(enc_div_pkg::FILTER_ADDR, 32'h0);
        read_reg(enc_div_pkg::STATUS_ADDR, 32'h0);
        steps(8, 1'b0);
        option_present <= 1'b1;
        read_reg(enc_div_pkg::STATUS_ADDR, 32'h1);
        num = 1;
        den = 1;
        steps(12, 1'b1);
        // refused settings leave the old value and raise the sticky flag
        foreach (bad_tab[i]) begin
            write_reg(enc_div_pkg::RATIO_ADDR, bad_tab[i], 1'b1);
            read_reg(enc_div_pkg::RATIO_ADDR, 32'h1);
        end
        read_reg(enc_div_pkg::STATUS_ADDR, 32'h3);
        write_reg(enc_div_pkg::STATUS_ADDR, 32'h2, 1'b0);
        read_reg(enc_div_pkg::STATUS_ADDR, 32'h1);
        write_reg(enc_div_pkg::FILTER_ADDR, 32'h10, 1'b1);
        read_reg(enc_div_pkg::FILTER_ADDR, 32'h0);
        apb(1'b0, enc_div_pkg::STEP_ADDR + 17'h4, 32'h0, 32'h0, 1'b1);
        // step sequence across the 128 to 1002 gap and at both ends
        foreach (step_tab[i]) begin
            write_reg(enc_div_pkg::RATIO_ADDR, {16'h0, step_tab[i][33:18]}, 1'b0);
            write_reg(enc_div_pkg::STEP_ADDR, {30'h0, step_tab[i][17:16]}, 1'b0);
            read_reg(enc_div_pkg::RATIO_ADDR, {16'h0, step_tab[i][15:0]});
        end
        read_reg(enc_div_pkg::STEP_ADDR, 32'h0);
        // boundary and random ratios under several filter settings
        for (int k = 0; k < 7; k++) begin
            lfsr = next_rand(lfsr);
            v = lfsr[8] ? 16'h03EA + 16'(lfsr[15:0] % 16'h007F) : 16'h0001 + 16'(lfsr[6:0]);
            v = (k < 4) ? fixed_tab[k] : v;
            f = (k * 5) % 16;
            write_reg(enc_div_pkg::FILTER_ADDR, 32'(f), 1'b0);
            read_reg(enc_div_pkg::FILTER_ADDR, 32'(f));
            filt = f;
            set_ratio(v);
            steps(2 * den + 3, 1'b0);
            steps(40, 1'b1);
        end
        // a pulse shorter than the filter window must not count
        write_reg(enc_div_pkg::FILTER_ADDR, 32'h3, 1'b0);
        filt = 3;
        set_ratio(16'h0001);
        @(posedge pclk);
        phase_a_pulse_in <= ~enc[1];
        repeat (3) @(posedge pclk);
        phase_a_pulse_in <= enc[1];
        repeat (10) @(posedge pclk);
        steps(8, 1'b1);
        repeat (20) @(posedge pclk);
        `CHK(pos_q.size(), 0)
        `CHK(jump_seen, 1'b0)
        complete_run();
    end
endmodule // encoder_pulse_divider_tb
